// ===== design/pirq_top.sv
// Interrupt pin logic for two serial channels and the parallel port.
// Assumes pending flags from the channel logic on core_clk and a strobe
// register port; acknowledge and master reset arrive from pins.
`timescale 1ns/1ps
module pirq_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [pirq_pkg::PIRQ_AW-1:0] reg_addr,
  input wire logic [pirq_pkg::PIRQ_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pirq_pkg::PIRQ_DW-1:0] reg_rdata,
  // Pending flags from the serial channels
  input wire logic [pirq_pkg::PIRQ_NCHAN-1:0][pirq_pkg::PIRQ_NSRC-1:0] serial_pending,
  // Pins from outside
  input wire logic master_reset_in,
  input wire logic pp_ack_in,
  // Serial interrupt lines
  output logic irq3_out,
  output logic irq3_oe,
  output logic irq4_out,
  output logic irq4_oe,
  // Parallel interrupt lines
  output logic irq5_out,
  output logic irq5_oe,
  output logic irq7_out,
  output logic irq7_oe,
  // Block interrupt
  output logic blk_irq
);
  import pirq_pkg::*;

  logic [PIRQ_RST_STAGES-1:0] rst_sync_reg;
  logic rst_n;
  pirq_state_type st_reg;
  pirq_state_type st_next;
  pirq_route_if rif ();
  logic [PIRQ_NCHAN-1:0] chan_req;
  logic [PIRQ_NEVT-1:0] evt_set;
  logic [PIRQ_NEVT-1:0] evt_clr;
  logic wr_src0;
  logic wr_src1;

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[PIRQ_RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[PIRQ_RST_STAGES-1];

  genvar c;
  generate
    for (c = 0; c < PIRQ_NCHAN; c++) begin : g_req
      // Any enabled pending source keeps the request up
      assign chan_req[c] = |(st_reg.src_en[c] & serial_pending[c]);
    end
  endgenerate

  assign rif.req = chan_req;
  assign rif.out_en = st_reg.out_en;
  assign rif.desig = st_reg.desig;

  pirq_route u_route (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  assign wr_src0 = reg_wr && (reg_addr == PIRQ_OFS_SRC_EN0);
  assign wr_src1 = reg_wr && (reg_addr == PIRQ_OFS_SRC_EN1);

  always_comb begin
    st_next = st_reg;
    evt_set = '0;
    evt_clr = '0;

    // Pins pass three flops; a change counts once stages two and three agree
    st_next.ack_sync = {st_reg.ack_sync[1:0], pp_ack_in};
    st_next.mr_sync = {st_reg.mr_sync[1:0], master_reset_in};
    if (st_reg.ack_sync[1] == st_reg.ack_sync[2]) begin
      st_next.ack_level = st_reg.ack_sync[2];
    end
    if (st_reg.mr_sync[1] == st_reg.mr_sync[2]) begin
      st_next.mr_level = st_reg.mr_sync[2];
    end

    // Events
    st_next.line_prev = rif.chan_line;
    evt_set[PIRQ_EVT_CH0] = rif.chan_line[0] && !st_reg.line_prev[0];
    evt_set[PIRQ_EVT_CH1] = rif.chan_line[1] && !st_reg.line_prev[1];
    evt_set[PIRQ_EVT_ACK] = st_next.ack_level && !st_reg.ack_level;
    evt_set[PIRQ_EVT_MR] = st_next.mr_level && !st_reg.mr_level;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        PIRQ_OFS_SRC_EN0: begin
          st_next.src_en[0] = reg_wdata[PIRQ_NSRC-1:0];
        end
        PIRQ_OFS_MCTL0: begin
          st_next.out_en[0] = reg_wdata[PIRQ_MCTL_OE_BIT];
        end
        PIRQ_OFS_DESIG0: begin
          st_next.desig[0] = reg_wdata[1:0];
        end
        PIRQ_OFS_SRC_EN1: begin
          st_next.src_en[1] = reg_wdata[PIRQ_NSRC-1:0];
        end
        PIRQ_OFS_MCTL1: begin
          st_next.out_en[1] = reg_wdata[PIRQ_MCTL_OE_BIT];
        end
        PIRQ_OFS_DESIG1: begin
          st_next.desig[1] = reg_wdata[1:0];
        end
        PIRQ_OFS_PP_CTRL: begin
          st_next.pp_irq_en = reg_wdata[PIRQ_PP_IRQ_EN_BIT];
        end
        PIRQ_OFS_PP_SEL: begin
          st_next.pp_sel = reg_wdata[1:0];
        end
        PIRQ_OFS_EVT_STAT: begin
          evt_clr = reg_wdata[PIRQ_NEVT-1:0];
        end
        PIRQ_OFS_EVT_MASK: begin
          st_next.evt_mask = reg_wdata[PIRQ_NEVT-1:0];
        end
        default: begin
        end
      endcase
    end

    // Set beats a same-cycle clear so no event is lost
    st_next.evt_stat = (st_reg.evt_stat & ~evt_clr) | evt_set;

    // Master reset clears enables, so serial lines drop and float
    if (st_reg.mr_level) begin
      st_next.src_en = '0;
      st_next.out_en = '0;
      st_next.desig = {PIRQ_RST_DESIG1, PIRQ_RST_DESIG0};
      st_next.pp_irq_en = 1'b0;
      st_next.pp_sel = PIRQ_RST_PP_SEL;
    end

    // Parallel line follows acknowledge only while enabled
    st_next.pp_out = st_reg.ack_level && st_reg.pp_irq_en;
    st_next.pp5_oe = st_reg.pp_irq_en && (st_reg.pp_sel == PIRQ_PP_SEL_LINE5);
    st_next.pp7_oe = st_reg.pp_irq_en && (st_reg.pp_sel == PIRQ_PP_SEL_LINE7);

    // Read data stand for one cycle only
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        PIRQ_OFS_SRC_EN0: begin
          st_next.rdata = {28'h0, st_reg.src_en[0]};
        end
        PIRQ_OFS_MCTL0: begin
          st_next.rdata = {28'h0, st_reg.out_en[0], 3'h0};
        end
        PIRQ_OFS_DESIG0: begin
          st_next.rdata = {30'h0, st_reg.desig[0]};
        end
        PIRQ_OFS_SRC_EN1: begin
          st_next.rdata = {28'h0, st_reg.src_en[1]};
        end
        PIRQ_OFS_MCTL1: begin
          st_next.rdata = {28'h0, st_reg.out_en[1], 3'h0};
        end
        PIRQ_OFS_DESIG1: begin
          st_next.rdata = {30'h0, st_reg.desig[1]};
        end
        PIRQ_OFS_PP_CTRL: begin
          st_next.rdata = {27'h0, st_reg.pp_irq_en, 4'h0};
        end
        PIRQ_OFS_PP_SEL: begin
          st_next.rdata = {30'h0, st_reg.pp_sel};
        end
        PIRQ_OFS_EVT_STAT: begin
          st_next.rdata = {28'h0, st_reg.evt_stat};
        end
        PIRQ_OFS_EVT_MASK: begin
          st_next.rdata = {28'h0, st_reg.evt_mask};
        end
        PIRQ_OFS_LIVE: begin
          st_next.rdata = {16'h0, serial_pending[1], serial_pending[0],
            st_reg.mr_level, st_reg.ack_level, rif.chan_line,
            rif.line4, rif.line3, st_reg.pp_out, 1'b0};
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.desig[0] <= PIRQ_RST_DESIG0;
      st_reg.desig[1] <= PIRQ_RST_DESIG1;
      st_reg.evt_stat <= PIRQ_RST_EVT;
      st_reg.evt_mask <= PIRQ_RST_EVT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign irq3_out = rif.line3;
  assign irq3_oe = rif.line3_oe;
  assign irq4_out = rif.line4;
  assign irq4_oe = rif.line4_oe;
  // Only the selected parallel pin carries the level and drives; the other stays low
  assign irq5_out = st_reg.pp_out && st_reg.pp5_oe;
  assign irq5_oe = st_reg.pp5_oe;
  assign irq7_out = st_reg.pp_out && st_reg.pp7_oe;
  assign irq7_oe = st_reg.pp7_oe;
  assign blk_irq = |(st_reg.evt_stat & st_reg.evt_mask);
endmodule

// ===== design/pirq_pkg.sv
// Constants and types for the peripheral interrupt pin logic.
// Assumes a 40 MHz core clock and a plain strobe register port.
package pirq_pkg;

  localparam int PIRQ_NCHAN = 2;
  localparam int PIRQ_AW = 8;
  localparam int PIRQ_DW = 32;
  localparam int PIRQ_NSRC = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] PIRQ_OFS_SRC_EN0 = 8'h00;
  localparam logic [7:0] PIRQ_OFS_MCTL0 = 8'h04;
  localparam logic [7:0] PIRQ_OFS_DESIG0 = 8'h08;
  localparam logic [7:0] PIRQ_OFS_SRC_EN1 = 8'h0c;
  localparam logic [7:0] PIRQ_OFS_MCTL1 = 8'h10;
  localparam logic [7:0] PIRQ_OFS_DESIG1 = 8'h14;
  localparam logic [7:0] PIRQ_OFS_PP_CTRL = 8'h18;
  localparam logic [7:0] PIRQ_OFS_PP_SEL = 8'h1c;
  localparam logic [7:0] PIRQ_OFS_EVT_STAT = 8'h20;
  localparam logic [7:0] PIRQ_OFS_EVT_MASK = 8'h24;
  localparam logic [7:0] PIRQ_OFS_LIVE = 8'h28;

  // Field positions
  localparam int PIRQ_MCTL_OE_BIT = 3;
  localparam int PIRQ_PP_IRQ_EN_BIT = 4;

  // Pending source bit order, also the source enable layout
  localparam int PIRQ_SRC_RX_ERR = 0;
  localparam int PIRQ_SRC_RX_DATA = 1;
  localparam int PIRQ_SRC_TX_EMPTY = 2;
  localparam int PIRQ_SRC_MODEM = 3;

  // Port designations
  localparam logic [1:0] PIRQ_COM1 = 2'h0;
  localparam logic [1:0] PIRQ_COM2 = 2'h1;
  localparam logic [1:0] PIRQ_COM3 = 2'h2;
  localparam logic [1:0] PIRQ_COM4 = 2'h3;

  // Parallel line selection
  localparam logic [1:0] PIRQ_PP_SEL_NONE = 2'h0;
  localparam logic [1:0] PIRQ_PP_SEL_LINE5 = 2'h1;
  localparam logic [1:0] PIRQ_PP_SEL_LINE7 = 2'h2;

  // Event status bits
  localparam int PIRQ_EVT_CH0 = 0;
  localparam int PIRQ_EVT_CH1 = 1;
  localparam int PIRQ_EVT_ACK = 2;
  localparam int PIRQ_EVT_MR = 3;
  localparam int PIRQ_NEVT = 4;

  // Values after reset
  localparam logic [3:0] PIRQ_RST_SRC_EN = 4'h0;
  localparam logic [1:0] PIRQ_RST_DESIG0 = PIRQ_COM1;
  localparam logic [1:0] PIRQ_RST_DESIG1 = PIRQ_COM2;
  localparam logic [1:0] PIRQ_RST_PP_SEL = PIRQ_PP_SEL_NONE;
  localparam logic [3:0] PIRQ_RST_EVT = 4'h0;
  localparam int PIRQ_SYNC_STAGES = 3;
  localparam int PIRQ_RST_STAGES = 2;

  typedef struct packed {
    logic [PIRQ_NCHAN-1:0][PIRQ_NSRC-1:0] src_en;
    logic [PIRQ_NCHAN-1:0] out_en;
    logic [PIRQ_NCHAN-1:0][1:0] desig;
    logic pp_irq_en;
    logic [1:0] pp_sel;
    logic [PIRQ_NEVT-1:0] evt_stat;
    logic [PIRQ_NEVT-1:0] evt_mask;
    logic [PIRQ_SYNC_STAGES-1:0] ack_sync;
    logic ack_level;
    logic [PIRQ_SYNC_STAGES-1:0] mr_sync;
    logic mr_level;
    logic [PIRQ_NCHAN-1:0] line_prev;
    logic pp_out;
    logic pp5_oe;
    logic pp7_oe;
    logic [PIRQ_DW-1:0] rdata;
  } pirq_state_type;

  typedef struct packed {
    logic line3;
    logic line3_oe;
    logic line4;
    logic line4_oe;
    logic [PIRQ_NCHAN-1:0] chan_line;
  } pirq_route_type;

endpackage

// ===== design/pirq_route_if.sv
// Carrier between the top and the serial line router.
// Assumes both ends share core_clk and the synchronised reset.
`timescale 1ns/1ps
interface pirq_route_if;
  logic [pirq_pkg::PIRQ_NCHAN-1:0] req;
  logic [pirq_pkg::PIRQ_NCHAN-1:0] out_en;
  logic [pirq_pkg::PIRQ_NCHAN-1:0][1:0] desig;
  logic line3;
  logic line3_oe;
  logic line4;
  logic line4_oe;
  logic [pirq_pkg::PIRQ_NCHAN-1:0] chan_line;

  modport ctl (
    output req,
    output out_en,
    output desig,
    input line3,
    input line3_oe,
    input line4,
    input line4_oe,
    input chan_line
  );
  modport rte (
    input req,
    input out_en,
    input desig,
    output line3,
    output line3_oe,
    output line4,
    output line4_oe,
    output chan_line
  );
endinterface

// ===== design/pirq_route.sv
// Router of serial channel requests onto interrupt lines 3 and 4.
// Assumes requests come from logic on core_clk; outputs are registered.
`timescale 1ns/1ps
module pirq_route (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Router side of the carrier
  pirq_route_if.rte rif
);
  import pirq_pkg::*;

  pirq_route_type st_reg;
  pirq_route_type st_next;
  logic [PIRQ_NCHAN-1:0] hit3;
  logic [PIRQ_NCHAN-1:0] hit4;

  genvar c;
  generate
    for (c = 0; c < PIRQ_NCHAN; c++) begin : g_chan
      assign hit3[c] = (rif.desig[c] == PIRQ_COM2) || (rif.desig[c] == PIRQ_COM4);
      assign hit4[c] = (rif.desig[c] == PIRQ_COM1) || (rif.desig[c] == PIRQ_COM3);
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // Level follows the request, so it drops once nothing enabled is pending
    st_next.chan_line = rif.req & rif.out_en;
    st_next.line3 = |(hit3 & rif.req & rif.out_en);
    st_next.line4 = |(hit4 & rif.req & rif.out_en);
    // Cleared output enable floats the line
    st_next.line3_oe = |(hit3 & rif.out_en);
    st_next.line4_oe = |(hit4 & rif.out_en);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rif.line3 = st_reg.line3;
  assign rif.line3_oe = st_reg.line3_oe;
  assign rif.line4 = st_reg.line4;
  assign rif.line4_oe = st_reg.line4_oe;
  assign rif.chan_line = st_reg.chan_line;
endmodule

// ===== sim/pirq_checker.sv
// Port checker for the interrupt pin logic.
// Assumes one clock domain and the raw active-low reset pin.
`timescale 1ns/1ps
module pirq_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pirq_pkg::PIRQ_DW-1:0] reg_rdata,
  // Outside inputs
  input wire logic [pirq_pkg::PIRQ_NCHAN-1:0][pirq_pkg::PIRQ_NSRC-1:0] serial_pending,
  input wire logic master_reset_in,
  input wire logic pp_ack_in,
  // Lines
  input wire logic irq3_out,
  input wire logic irq3_oe,
  input wire logic irq4_out,
  input wire logic irq4_oe,
  input wire logic irq5_out,
  input wire logic irq5_oe,
  input wire logic irq7_out,
  input wire logic irq7_oe
);
  import pirq_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_float_low: assert property (!(irq3_out && !irq3_oe) && !(irq4_out && !irq4_oe)
    && !(irq5_out && !irq5_oe) && !(irq7_out && !irq7_oe))
    else $error("Line high while released");
  a_idle_low: assert property ($past(serial_pending) == '0 |-> !irq3_out && !irq4_out)
    else $error("Serial line high with nothing pending");
  a_rise_cause: assert property ($rose(irq3_out) || $rose(irq4_out) |-> $past(|serial_pending))
    else $error("Serial line rose without a pending flag");
  a_oe_cause: assert property ($rose(irq3_oe) || $rose(irq4_oe) |-> $past(reg_wr, 2))
    else $error("Serial enable rose without a write");
  a_mr_clears: assert property (master_reset_in [*8] |=> !(irq3_oe || irq4_oe || irq5_oe || irq7_oe))
    else $error("Line still driven in master reset");
  a_pp_follow: assert property (((irq5_oe || irq7_oe) && $stable(pp_ack_in)) [*6]
    |-> (irq5_out || irq7_out) == pp_ack_in)
    else $error("Parallel line not following acknowledge");
  a_pp_one_line: assert property (!(irq5_oe && irq7_oe))
    else $error("Both parallel lines enabled");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("Read data outside the read cycle");
endmodule
bind pirq_top pirq_checker u_chk (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_pending(serial_pending),
  .master_reset_in(master_reset_in), .pp_ack_in(pp_ack_in), .irq3_out(irq3_out),
  .irq3_oe(irq3_oe), .irq4_out(irq4_out), .irq4_oe(irq4_oe), .irq5_out(irq5_out),
  .irq5_oe(irq5_oe), .irq7_out(irq7_out), .irq7_oe(irq7_oe));

// ===== sim/pirq_host_model.sv
// Host interrupt controller model sensing the four request wires.
// Assumes no pull on the wires.
`timescale 1ns/1ps
module pirq_host_model (
  // Clock
  input wire logic core_clk,
  // Request wires
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe,
  // Sensed levels
  output logic [3:0] line_lvl
);
  logic [3:0] last_reg;
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (line_oe[i]) begin
        last_reg[i] <= line_out[i];
      end
    end
  end
  // No pull: a released wire reads as the inverse of its last driven level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line_lvl[i] = line_oe[i] ? line_out[i] : ~last_reg[i];
    end
  end
endmodule

// ===== sim/pirq_top_tb.sv
// Testbench of the interrupt pin logic, with the host model.
// Assumes the checker is bound to the top module.
`timescale 1ns/1ps
module pirq_top_tb;
  import pirq_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [PIRQ_AW-1:0] reg_addr = '0;
  logic [PIRQ_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [PIRQ_DW-1:0] reg_rdata;
  logic [PIRQ_NCHAN-1:0][PIRQ_NSRC-1:0] serial_pending = '0;
  logic master_reset_in = 1'b0;
  logic pp_ack_in = 1'b0;
  logic irq3_out, irq3_oe, irq4_out, irq4_oe, irq5_out, irq5_oe, irq7_out, irq7_oe;
  logic blk_irq;
  logic [3:0] lvl;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  pirq_top dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_pending(serial_pending), .master_reset_in(master_reset_in),
    .pp_ack_in(pp_ack_in), .irq3_out(irq3_out), .irq3_oe(irq3_oe), .irq4_out(irq4_out),
    .irq4_oe(irq4_oe), .irq5_out(irq5_out), .irq5_oe(irq5_oe), .irq7_out(irq7_out),
    .irq7_oe(irq7_oe), .blk_irq(blk_irq));
  pirq_host_model host (.core_clk(core_clk),
    .line_out({irq7_out, irq5_out, irq4_out, irq3_out}),
    .line_oe({irq7_oe, irq5_oe, irq4_oe, irq3_oe}), .line_lvl(lvl));
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, e, reg_rdata);
  endtask
  task automatic pend(input logic [7:0] v);
    @(posedge core_clk);
    serial_pending <= v;
    step(2);
  endtask
  // Bits: oe of lines 7,5,4,3 then levels of lines 7,5,4,3
  task automatic sig(input logic [7:0] e, input string what);
    chk(what, {24'h0, e}, {24'h0, irq7_oe, irq5_oe, irq4_oe, irq3_oe,
      irq7_out, irq5_out, irq4_out, irq3_out});
    chk("wire", {28'h0, e[3:0]}, {28'h0, lvl & e[7:4]});
  endtask
  // Ceiling well above the few hundred cycles the tests take
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    logic on3;
    logic [7:0] off;
    logic [7:0] ev;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    step(3);
    rd(PIRQ_OFS_DESIG0, {30'h0, PIRQ_RST_DESIG0}, "desig0");
    rd(PIRQ_OFS_DESIG1, {30'h0, PIRQ_RST_DESIG1}, "desig1");
    rd(PIRQ_OFS_SRC_EN1, {28'h0, PIRQ_RST_SRC_EN}, "src_en1");
    $display("Test reset values done");
    for (int c = 0; c < 2; c++) begin
      off = (c == 1) ? 8'h0c : 8'h00;
      for (int d = 0; d < 4; d++) begin
        on3 = (d == PIRQ_COM2) || (d == PIRQ_COM4);
        wr(PIRQ_OFS_SRC_EN0 + off, 32'hf);
        wr(PIRQ_OFS_MCTL0 + off, 32'h1 << PIRQ_MCTL_OE_BIT);
        wr(PIRQ_OFS_DESIG0 + off, 32'(d));
        pend(8'h2 << (4 * c));
        sig({2'b0, !on3, on3, 2'b0, !on3, on3}, "route");
        pend(8'h0);
        sig({2'b0, !on3, on3, 4'h0}, "service");
        wr(PIRQ_OFS_MCTL0 + off, 32'h0);
        step(2);
        sig(8'h0, "float");
      end
    end
    $display("Test routing done");
    wr(PIRQ_OFS_DESIG0, {30'h0, PIRQ_COM1});
    wr(PIRQ_OFS_MCTL0, 32'h1 << PIRQ_MCTL_OE_BIT);
    for (int b = 0; b < 4; b++) begin
      wr(PIRQ_OFS_SRC_EN0, 32'h1 << b);
      pend(8'hf & ~(8'h1 << b));
      sig(8'h20, "others");
      pend(8'h1 << b);
      sig(8'h22, "source");
    end
    wr(PIRQ_OFS_SRC_EN0, 32'hf);
    pend(8'h3);
    pend(8'h2);
    sig(8'h22, "one left");
    pend(8'h0);
    sig(8'h20, "none left");
    pend(8'h4);
    wr(PIRQ_OFS_SRC_EN0, 32'h0);
    step(2);
    sig(8'h20, "disabled");
    $display("Test serial sources done");
    wr(PIRQ_OFS_PP_CTRL, 32'h1 << PIRQ_PP_IRQ_EN_BIT);
    for (int s = 1; s < 4; s++) begin
      ev = (s == 1) ? 8'h44 : (s == 2) ? 8'h88 : 8'h00;
      wr(PIRQ_OFS_PP_SEL, 32'(s));
      @(posedge core_clk);
      pp_ack_in <= 1'b1;
      step(8);
      sig(8'h20 | ev, "ack high");
      @(posedge core_clk);
      pp_ack_in <= 1'b0;
      step(8);
      sig(8'h20 | (ev & 8'hf0), "ack low");
    end
    wr(PIRQ_OFS_PP_SEL, {30'h0, PIRQ_PP_SEL_LINE5});
    wr(PIRQ_OFS_PP_CTRL, 32'h0);
    step(2);
    sig(8'h20, "pp off");
    $display("Test parallel done");
    wr(PIRQ_OFS_SRC_EN0, 32'hf);
    wr(PIRQ_OFS_PP_CTRL, 32'h1 << PIRQ_PP_IRQ_EN_BIT);
    pend(8'h1);
    sig(8'h62, "before reset");
    @(posedge core_clk);
    master_reset_in <= 1'b1;
    step(10);
    sig(8'h00, "master reset");
    @(posedge core_clk);
    master_reset_in <= 1'b0;
    step(6);
    rd(PIRQ_OFS_SRC_EN0, 32'h0, "src_en0");
    rd(PIRQ_OFS_MCTL0, 32'h0, "mctl0");
    pend(8'h0);
    $display("Test master reset done");
    chk("blk masked", 32'h0, {31'h0, blk_irq});
    wr(PIRQ_OFS_EVT_MASK, 32'hf);
    step(2);
    chk("blk", 32'h1, {31'h0, blk_irq});
    rd(PIRQ_OFS_EVT_STAT, 32'hf, "events");
    wr(PIRQ_OFS_EVT_STAT, 32'hf);
    step(2);
    chk("blk clear", 32'h0, {31'h0, blk_irq});
    rd(8'h30, 32'h0, "unmapped");
    $display("Test events done");
    test_done();
  end
endmodule
